// ### core/qde_delay_mem.sv
`include "qde_regs.svh"
`default_nettype none
module qde_delay_mem (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] waddr,
    input wire logic [2:0] wdata,
    input wire logic [7:0] raddr,
    output logic [2:0] rdata
);

    qde_pkg::qde_mem_st_t st_r;
    qde_pkg::qde_mem_st_t st_nxt;

    // read before write: same-address access returns the old word
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = st_r.mem[raddr];
        st_nxt.mem[waddr] = wdata;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rd;

endmodule
`default_nettype wire

// ### core/qde_pkg.sv
`include "qde_regs.svh"
`default_nettype none
package qde_pkg;

    typedef struct packed {
        logic [3:0] line_break;
        logic [3:0] low_amp;
        logic over_freq;
    } qde_flt_t;

    typedef struct packed {
        logic z;
        logic b;
        logic a;
    } qde_qd_t;

    typedef struct packed {
        logic div_off;
        logic auto_clr;
        logic [5:0] code;
    } qde_sw_t;

    typedef struct packed {
        logic [10:0] rsvd;
        qde_flt_t flt;
        logic primed;
        logic sw_done;
        logic settled;
        logic err;
        qde_sw_t sw;
    } qde_info_t;

    typedef struct packed {
        logic [2:0] settled;
        logic [2:0] err_clr;
        logic [2:0] err_set;
    } qde_dummy_t;

    typedef struct packed {
        logic [`QDE_DEPTH-1:0][2:0] mem;
        logic [2:0] rd;
    } qde_mem_st_t;

    typedef struct packed {
        qde_qd_t qs1;
        qde_qd_t qs2;
        qde_flt_t fs1;
        qde_flt_t fs2;
        logic [1:0] ss1;
        logic [1:0] ss2;
        logic [1:0] ss3;
        logic [7:0] ws1;
        logic [7:0] ws2;
        logic [1:0] cap_cnt;
        logic sw_done;
        qde_sw_t sw;
        logic [7:0] wr_ptr;
        logic primed;
        logic [2:0] dl_prev;
        logic [7:0] div_cnt;
        logic [1:0] q_phase;
        qde_qd_t qd_o;
        logic err;
        logic [4:0] settle_cnt;
        logic settled;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } qde_st_t;

endpackage
`default_nettype wire

// ### core/qde_regs.svh
`ifndef QDE_REGS_SVH
`define QDE_REGS_SVH

// register byte addresses
`define QDE_A_STATUS 8'h00
`define QDE_A_MASK 8'h04
`define QDE_A_CTRL 8'h08
`define QDE_A_INFO 8'h0c

// axi responses
`define QDE_RESP_OKAY 2'h0
`define QDE_RESP_DECERR 2'h3

// switch-bank divider code base: ratio is 2 * (base - code)
`define QDE_CODE_BASE 7'h40

// switch settle wait after reset release, in cycles
`define QDE_CAP_WAIT 2'h3

// timing
`define QDE_CLK_NS 20
`define QDE_DELAY_NS 3000
`define QDE_DELAY_CYC ((`QDE_DELAY_NS) / (`QDE_CLK_NS))
// sync, write, read register and output register add four cycles; the tap subtracts three
`define QDE_TAP 8'(`QDE_DELAY_CYC - 3)
`define QDE_DEPTH 256
`define QDE_PTR_MAX 8'hff

// accuracy settling: full sine periods
`define QDE_SETTLE_LAST 5'h13

`endif

// ### core/qde_top.sv
// Summary of operation
// - divided ratio is twice sixty-four minus switch code; all-ones 1:2, zero 1:128
// - divider-off switch low divides; high passes pulses through at 1:1
// - any fault drives both error lamp and error output
// - a broken sine or cosine line flags an error
// - too low amplitude on a sine or cosine line flags an error
// - input overfrequency, output unable to follow, flags an error
// - reference mark pair is never checked and never raises an error
// - auto-clear switch high clears on fault removal; low latches until acknowledge
// - bypassed latency from input to output is about three microseconds
// - enabling the divider adds no stage of latency; it shares the bypass output register
// - latency is fixed, independent of frequency
// - full accuracy only after twenty full input sine periods
// - switch bank is captured only once after power-up
`include "qde_regs.svh"
`default_nettype none
module qde_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire qde_pkg::qde_qd_t qd_in,
    input wire logic sin_sign,
    input wire qde_pkg::qde_flt_t flt_in,
    input wire logic [7:0] divider_switch_bank,
    input wire logic err_ack,
    output qde_pkg::qde_qd_t qd_out,
    output logic err_led,
    output logic err_out,
    output logic settled,
    output logic irq,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    qde_pkg::qde_st_t st_r;
    qde_pkg::qde_st_t st_nxt;
    qde_pkg::qde_info_t info;
    logic [7:0] mem_raddr;
    logic [2:0] mem_rd;
    logic [1:0] pg;
    logic [1:0] cg;
    logic [1:0] dg;
    logic up;
    logic dn;
    logic run;
    logic [7:0] lim;
    logic fault;
    logic ack_ev;
    logic soft_ack;
    logic [2:0] w1c;
    logic [2:0] ev;
    logic sin_rise;

    // fixed tap behind the write pointer: constant delay at any frequency
    assign mem_raddr = st_r.wr_ptr - `QDE_TAP;

    qde_delay_mem qde_delay_mem_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .waddr(st_r.wr_ptr),
        .wdata(st_r.qs2),
        .raddr(mem_raddr),
        .rdata(mem_rd)
    );

    always_comb begin
        info = '0;
        info.flt = st_r.fs2;
        info.primed = st_r.primed;
        info.sw_done = st_r.sw_done;
        info.settled = st_r.settled;
        info.err = st_r.err;
        info.sw = st_r.sw;
    end

    // gray phase to binary count: {b, a^b}
    assign pg = {st_r.dl_prev[1], st_r.dl_prev[1] ^ st_r.dl_prev[0]};
    assign cg = {mem_rd[1], mem_rd[1] ^ mem_rd[0]};
    assign dg = cg - pg;
    assign run = st_r.primed && st_r.sw_done;
    // a jump of two phases is illegal and dropped
    assign up = run && (dg == 2'h1);
    assign dn = run && (dg == 2'h3);
    assign lim = 8'({(`QDE_CODE_BASE - {1'b0, st_r.sw.code}), 1'b0} - 8'h1);
    // reference pair not in the fault vector
    assign fault = |st_r.fs2;
    assign sin_rise = st_r.ss2[0] && !st_r.ss3[0];

    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready = !st_r.w_got && !st_r.bvalid;
    assign arready = !st_r.rvalid;

    always_comb begin
        st_nxt = st_r;
        w1c = '0;
        soft_ack = 1'b0;
        // pin synchronisers
        st_nxt.qs1 = qd_in;
        st_nxt.qs2 = st_r.qs1;
        st_nxt.fs1 = flt_in;
        st_nxt.fs2 = st_r.fs1;
        st_nxt.ss1 = {err_ack, sin_sign};
        st_nxt.ss2 = st_r.ss1;
        st_nxt.ss3 = st_r.ss2;
        st_nxt.ws1 = divider_switch_bank;
        st_nxt.ws2 = st_r.ws1;

        // switches taken once; later moves need a new power-up
        if (!st_r.sw_done) begin
            st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
            if (st_r.cap_cnt == `QDE_CAP_WAIT) begin
                st_nxt.sw = qde_pkg::qde_sw_t'(st_r.ws2);
                st_nxt.sw_done = 1'b1;
            end
        end

        // axi write channel
        if (awvalid && awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `QDE_RESP_OKAY;
            if (st_r.aw_addr == `QDE_A_STATUS) begin
                if (st_r.wstrb[0]) begin
                    w1c = st_r.wdata[2:0];
                end
            end else if (st_r.aw_addr == `QDE_A_MASK) begin
                if (st_r.wstrb[0]) begin
                    st_nxt.mask = st_r.wdata[2:0];
                end
            end else if (st_r.aw_addr == `QDE_A_CTRL) begin
                soft_ack = st_r.wstrb[0] && st_r.wdata[0];
            end else if (st_r.aw_addr == `QDE_A_INFO) begin
                st_nxt.bresp = `QDE_RESP_OKAY;
            end else begin
                st_nxt.bresp = `QDE_RESP_DECERR;
            end
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // axi read channel
        if (arvalid && arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `QDE_RESP_OKAY;
            st_nxt.rdata = '0;
            if (araddr == `QDE_A_STATUS) begin
                st_nxt.rdata[2:0] = st_r.status;
            end else if (araddr == `QDE_A_MASK) begin
                st_nxt.rdata[2:0] = st_r.mask;
            end else if (araddr == `QDE_A_CTRL) begin
                st_nxt.rdata = '0;
            end else if (araddr == `QDE_A_INFO) begin
                st_nxt.rdata = info;
            end else begin
                st_nxt.rresp = `QDE_RESP_DECERR;
            end
        end
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // delay line: output waits for the ring to fill once
        st_nxt.wr_ptr = st_r.wr_ptr + 8'h1;
        if (st_r.wr_ptr == `QDE_PTR_MAX) begin
            st_nxt.primed = 1'b1;
        end
        st_nxt.dl_prev = mem_rd;

        // divider counts steps both ways so direction survives
        if (up) begin
            if (st_r.div_cnt >= lim) begin
                st_nxt.div_cnt = '0;
                st_nxt.q_phase = st_r.q_phase + 2'h1;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 8'h1;
            end
        end else if (dn) begin
            if (st_r.div_cnt == '0) begin
                st_nxt.div_cnt = lim;
                st_nxt.q_phase = st_r.q_phase - 2'h1;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt - 8'h1;
            end
        end
        if (run) begin
            st_nxt.qd_o.z = mem_rd[2];
            if (st_r.sw.div_off) begin
                st_nxt.qd_o.a = mem_rd[0];
                st_nxt.qd_o.b = mem_rd[1];
            end else begin
                // same register stage as bypass, fed from the next counted phase
                st_nxt.qd_o.a = st_nxt.q_phase[1] ^ st_nxt.q_phase[0];
                st_nxt.qd_o.b = st_nxt.q_phase[1];
            end
        end

        // error: a fault present wins over any acknowledge
        ack_ev = (st_r.ss2[1] && !st_r.ss3[1]) || soft_ack;
        if (st_r.sw.auto_clr) begin
            st_nxt.err = fault;
        end else if (fault) begin
            st_nxt.err = 1'b1;
        end else if (ack_ev) begin
            st_nxt.err = 1'b0;
        end

        // accuracy settling restarts after any fault
        if (fault) begin
            st_nxt.settle_cnt = '0;
            st_nxt.settled = 1'b0;
        end else if (sin_rise && !st_r.settled) begin
            if (st_r.settle_cnt == `QDE_SETTLE_LAST) begin
                st_nxt.settled = 1'b1;
            end else begin
                st_nxt.settle_cnt = st_r.settle_cnt + 5'h1;
            end
        end

        // sticky events; a new event beats a same-cycle clear
        ev = {st_nxt.settled && !st_r.settled, !st_nxt.err && st_r.err, st_nxt.err && !st_r.err};
        st_nxt.status = (st_r.status & ~w1c) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign qd_out = st_r.qd_o;
    assign err_led = st_r.err;
    assign err_out = st_r.err;
    assign settled = st_r.settled;
    assign irq = st_r.irq;
    assign bresp = st_r.bresp;
    assign bvalid = st_r.bvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign rvalid = st_r.rvalid;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_err_both;
        fault |=> err_led && err_out;
    endproperty
    a_err_both: assert property (p_err_both) else $error("fault did not raise lamp and output");

    property p_break;
        (st_r.fs2.line_break != '0) |=> st_r.err;
    endproperty
    a_break: assert property (p_break) else $error("line break not flagged");

    property p_lowamp;
        (st_r.fs2.low_amp != '0) |=> st_r.err;
    endproperty
    a_lowamp: assert property (p_lowamp) else $error("low amplitude not flagged");

    property p_ovf;
        st_r.fs2.over_freq |=> st_r.err;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overfrequency not flagged");

    property p_auto;
        st_r.sw.auto_clr && !fault |=> !st_r.err;
    endproperty
    a_auto: assert property (p_auto) else $error("auto mode error did not clear");

    sequence s_latched_hold;
        !st_r.sw.auto_clr && st_r.err && !ack_ev;
    endsequence
    property p_latch;
        s_latched_hold |=> st_r.err;
    endproperty
    a_latch: assert property (p_latch) else $error("latched error cleared without acknowledge");

    property p_ack_blocked;
        st_r.err && fault |=> st_r.err;
    endproperty
    a_ack_blocked: assert property (p_ack_blocked) else $error("error cleared while fault present");

    property p_sw_hold;
        st_r.sw_done |=> st_r.sw_done && $stable(st_r.sw);
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("switch setting changed after capture");

    property p_bypass;
        run && st_r.sw.div_off |=> qd_out.a == $past(mem_rd[0]) && qd_out.b == $past(mem_rd[1]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output not one to one");

    sequence s_wrap_up;
        up && st_r.div_cnt == lim;
    endsequence
    property p_div_wrap;
        s_wrap_up |=> st_r.div_cnt == '0 && st_r.q_phase == $past(st_r.q_phase) + 2'h1;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider wrap wrong");

    property p_quad;
        st_r.q_phase != $past(st_r.q_phase) |-> (st_r.q_phase - $past(st_r.q_phase)) != 2'h2;
    endproperty
    a_quad: assert property (p_quad) else $error("output phase jumped by two");

    property p_tap;
        run |-> mem_rd == $past(st_r.qs2, `QDE_TAP + 8'h1);
    endproperty
    a_tap: assert property (p_tap) else $error("delay tap not fixed");

    property p_settle;
        sin_rise && !fault && st_r.settle_cnt == `QDE_SETTLE_LAST |=> settled;
    endproperty
    a_settle: assert property (p_settle) else $error("settled not raised after twenty periods");

    property p_irq;
        ##1 irq == |($past(st_nxt.status) & $past(st_nxt.mask));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ### tb/qde_partner.sv
`default_nettype none
module qde_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire qde_pkg::qde_qd_t qd,
    output var logic err_ack,
    output var int pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_ph;
    wire logic [1:0] ph = {qd.b, qd.a ^ qd.b};
    initial err_ack = 1'b0;
    // up/down position counter on the quadrature pair; z is ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            pos <= 0;
            last_ph <= 2'h0;
        end else begin
            if (2'(ph - last_ph) == 2'h1) begin
                pos <= pos + 1;
            end else if (2'(ph - last_ph) == 2'h3) begin
                pos <= pos - 1;
            end
            last_ph <= ph;
        end
    end
    // short acknowledge pulse; the device decides whether it clears
    task automatic ack();
        @(posedge aclk);
        err_ack <= 1'b1;
        repeat (2) @(posedge aclk);
        err_ack <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/quadrature_divider_error_monitor_tb_top.sv
`include "qde_regs.svh"
`default_nettype none
module quadrature_divider_error_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    qde_pkg::qde_qd_t qd_in = '0;
    logic sin_sign = 1'b0;
    qde_pkg::qde_flt_t flt_in = '0;
    logic [7:0] sw_bank = 8'h00;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire logic err_ack, awready, wready, bvalid, arready, rvalid, err_led, err_out, settled, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire qde_pkg::qde_qd_t qd_out;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int pos, n, div_n;
    int codes[2] = '{62, 0};
    logic [31:0] lfsr_st = 32'hb040;
    logic [1:0] ph = 2'h0;
    logic [31:0] rd;
    logic [1:0] rsp;

    always #10 aclk = ~aclk;

    qde_top qde_top_i (.aclk(aclk), .aresetn(aresetn), .qd_in(qd_in), .sin_sign(sin_sign),
        .flt_in(flt_in), .divider_switch_bank(sw_bank), .err_ack(err_ack), .qd_out(qd_out),
        .err_led(err_led), .err_out(err_out), .settled(settled), .irq(irq), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    qde_partner qde_partner_i (.aclk(aclk), .aresetn(aresetn), .qd(qd_out), .err_ack(err_ack), .pos(pos));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
    end

    // each valid held until its own ready is seen at a rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) begin
                awvalid <= 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) begin
                arvalid <= 1'b0;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic boot(input logic [7:0] sw);
        aresetn <= 1'b0;
        sw_bank <= sw;
        ph = 2'h0;
        qd_in <= '0;
        flt_in <= '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        sw_bank <= ~sw;
        repeat (300) @(posedge aclk);
        axr(`QDE_A_INFO, rd, rsp);
        chk(rd & 32'hfff, 32'hc00 | sw);
    endtask

    task automatic drive(input logic [1:0] d);
        ph = ph + d;
        qd_in <= '{z: qd_in.z, b: ph[1], a: ph[1] ^ ph[0]};
    endtask

    task automatic step(input int k, input logic [1:0] d);
        for (int i = 0; i < k; i++) begin
            drive(d);
            repeat (2) @(posedge aclk);
        end
    endtask

    task automatic lat();
        qde_pkg::qde_qd_t o;
        int c;
        o = qd_out;
        c = 0;
        drive(2'h1);
        do begin
            @(posedge aclk);
            #1;
            c++;
        end while (qd_out === o);
        chk(c, `QDE_DELAY_CYC + 1);
        @(posedge aclk);
    endtask

    initial begin
        boot(8'hbf);
        lat();
        repeat (37) @(posedge aclk);
        lat();
        lfsr_st = lfsr_next(lfsr_st);
        n = int'(lfsr_st[4:0]) + 1;
        step(n, 2'h1);
        repeat (200) @(posedge aclk);
        chk(pos, n + 2);
        for (int i = 0; i < 3; i++) begin
            qd_in <= '{z: ~qd_in.z, b: qd_in.b, a: qd_in.a};
            repeat (3) @(posedge aclk);
        end
        repeat (152) @(posedge aclk);
        chk(qd_out.z, 1'b1);
        chk(err_led, 1'b0);
        for (int i = 0; i < 9; i++) begin
            flt_in <= qde_pkg::qde_flt_t'(9'h1 << i);
            repeat (6) @(posedge aclk);
            chk({err_led, err_out}, 2'h3);
            qde_partner_i.ack();
            repeat (6) @(posedge aclk);
            chk(err_led, 1'b1);
            flt_in <= '0;
            repeat (6) @(posedge aclk);
            chk({err_led, err_out}, 2'h3);
            if (i == 8) axw(`QDE_A_CTRL, 32'h1, rsp);
            else qde_partner_i.ack();
            repeat (6) @(posedge aclk);
            chk({err_led, err_out}, 2'h0);
        end
        axr(`QDE_A_STATUS, rd, rsp);
        chk(rd, 32'h3);
        axw(`QDE_A_MASK, 32'h1, rsp);
        chk(rsp, `QDE_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(irq, 1'b1);
        axw(`QDE_A_STATUS, 32'h1, rsp);
        repeat (4) @(posedge aclk);
        chk(irq, 1'b0);
        axr(`QDE_A_STATUS, rd, rsp);
        chk(rd, 32'h2);
        axr(`QDE_A_MASK, rd, rsp);
        chk(rsp, `QDE_RESP_OKAY);
        chk(rd, 32'h1);
        axw(8'h10, 32'h5, rsp);
        chk(rsp, `QDE_RESP_DECERR);
        axr(8'h10, rd, rsp);
        chk(rsp, `QDE_RESP_DECERR);
        chk(rd, 32'h0);
        // divided mode with auto clear; deepest ratio 1:128 and ratio 1:4
        foreach (codes[j]) begin
            boot(8'h40 | 8'(codes[j]));
            div_n = 2 * (64 - codes[j]);
            lfsr_st = lfsr_next(lfsr_st);
            n = div_n * (int'(lfsr_st[1:0]) + 1);
            step(n, 2'h1);
            repeat (200) @(posedge aclk);
            chk(pos, n / div_n);
            step(n, 2'h3);
            repeat (200) @(posedge aclk);
            chk(pos, 0);
        end
        for (int i = 0; i < 20; i++) begin
            if (i == 19) chk(settled, 1'b0);
            sin_sign <= 1'b1;
            repeat (2) @(posedge aclk);
            sin_sign <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        chk(settled, 1'b1);
        flt_in <= '{line_break: 4'h0, low_amp: 4'h0, over_freq: 1'b1};
        repeat (6) @(posedge aclk);
        chk(err_out, 1'b1);
        flt_in <= '0;
        repeat (6) @(posedge aclk);
        chk({err_led, err_out}, 2'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
